//--- logic/power_mode_controller.sv
/*
 Operating-mode and low-power controller with its AXI4-Lite registers.
 Assumes the CPU core pulses stop_exec and clr_wdt for one cycle, that
 oscillator ticks are one-cycle pulses, and that aclk never stops.
*/
`timescale 1ns/1ps
module power_mode_controller
   import power_mode_pkg::*;
#(
   parameter int PINS = 8,
   parameter int INTS = 8,
   parameter int LOW_CYCLES = LOW_XTAL_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stop_exec,
   input wire logic clr_wdt,
   input wire logic wdt_overflow,
   input wire logic stack_full,
   input wire logic [PINS-1:0] port_a,
   input wire logic [INTS-1:0] int_req,
   input wire logic [INTS-1:0] int_enable,
   input wire logic high_osc_tick,
   input wire logic low_osc_tick,
   output logic cpu_halt,
   output logic hold_state,
   output logic resume_next,
   output logic int_take,
   output logic pc_sp_reset,
   output logic wdt_clear,
   output logic wdt_hold,
   output logic system_clock_en,
   output logic timebase_clock_en,
   output logic sub_clock_en,
   output logic wdt_source_en,
   output logic fast_clock_en,
   output logic low_osc_en,
   output logic sysclk_slow,
   output logic periph_clock_slow,
   output logic run_on_sub
);
   import power_mode_pkg::*;

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [7:0] mode_r;
   logic [7:0] ctrl_r;
   logic [PINS-1:0] wake_en_r;
   logic powerdown_flag_r;
   logic timeout_flag_r;
   logic high_osc_ready_r;
   logic low_osc_ready_r;
   state_type state_r;
   lp_mode_type lp_mode_r;
   cause_type cause_r;
   logic [INTS-1:0] cause_int_r;
   logic slow_r;
   logic subrun_r;
   logic fast_on_r;
   logic low_on_r;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane_r;

   logic high_clock_select;
   logic idle_on_stop;
   logic fast_wake_enable;
   logic [2:0] clock_divider_select;
   logic sysclk_in_idle;
   logic wdt_enable;
   logic lvd_enable;
   logic high_is_xtal;
   logic want_slow;
   logic port_wake;
   logic [INTS-1:0] int_new;
   logic wake_any;
   logic done_high;
   logic done_low;
   logic enter_lp;
   logic wr_fire;
   logic [31:0] status_word;
   lp_mode_type lp_sel;

   assign high_clock_select = mode_r[HCS_BIT];
   assign idle_on_stop = mode_r[IDLE_BIT];
   assign fast_wake_enable = mode_r[FAST_WAKE_BIT];
   assign clock_divider_select = mode_r[CDS_LSB +: 3];
   assign sysclk_in_idle = ctrl_r[SYSIDLE_BIT];
   assign wdt_enable = ctrl_r[WDT_EN_BIT];
   assign lvd_enable = ctrl_r[LVD_EN_BIT];
   assign high_is_xtal = ctrl_r[XTAL_BIT];

   assign want_slow = !high_clock_select && (clock_divider_select <= CDS_SLOW_MAX);

   // Low-power mode picked by the stop instruction
   always_comb begin
      lp_sel = PAUSE_FULL;
      if (!idle_on_stop && !wdt_enable && !lvd_enable) lp_sel = DEEP_STOP;
      else if (!idle_on_stop) lp_sel = STOP_SUB;
      else if (!sysclk_in_idle) lp_sel = PAUSE_SUB;
      else lp_sel = PAUSE_FULL;
   end

   assign enter_lp = (state_r == ST_RUN) && stop_exec;
   assign wake_any = (state_r == ST_LOW_POWER) && (port_wake || (|int_new) || wdt_overflow);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   startup_timer #(
      .LOW_CYCLES(LOW_CYCLES)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .high_is_xtal(high_is_xtal),
      .req_high(fast_on_r && !high_osc_ready_r),
      .req_low(low_on_r && !low_osc_ready_r),
      .tick_high(high_osc_tick),
      .tick_low(low_osc_tick),
      .done_high(done_high),
      .done_low(done_low)
   );

   wake_detect #(
      .PINS(PINS),
      .INTS(INTS)
   ) u_wake (
      .aclk(aclk),
      .aresetn(aresetn),
      .armed(state_r == ST_LOW_POWER),
      .port_a(port_a),
      .port_wake_enable(wake_en_r),
      .int_req(int_req),
      .port_wake(port_wake),
      .int_new(int_new)
   );

   // ----------------------------------------
   // Operating state machine
   // ----------------------------------------
   // Wake cause is latched so the CPU answer is given once clocks are good
   always_ff @(posedge aclk) begin
      resume_next <= 1'b0;
      int_take <= 1'b0;
      pc_sp_reset <= 1'b0;
      if (!aresetn) begin
         state_r <= ST_WAKE; // Power-on waits for the fast oscillator too
         lp_mode_r <= DEEP_STOP;
         cause_r <= CAUSE_PORT;
         cause_int_r <= '0;
         subrun_r <= 1'b0;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (enter_lp) begin
                  state_r <= ST_LOW_POWER;
                  lp_mode_r <= lp_sel;
               end
            end
            ST_LOW_POWER: begin
               if (wake_any) begin
                  state_r <= ST_WAKE;
                  cause_int_r <= int_new;
                  if (wdt_overflow) cause_r <= CAUSE_WDT;
                  else if (|int_new) cause_r <= CAUSE_INT;
                  else cause_r <= CAUSE_PORT;
                  subrun_r <= !slow_r && high_is_xtal && fast_wake_enable &&
                              (lp_mode_r == STOP_SUB || lp_mode_r == PAUSE_SUB);
               end
            end
            ST_WAKE: begin
               if (subrun_r || (slow_r ? low_osc_ready_r : high_osc_ready_r)) begin
                  state_r <= ST_RUN;
                  if (cause_r == CAUSE_WDT) pc_sp_reset <= 1'b1;
                  else if (cause_r == CAUSE_INT && |(cause_int_r & int_enable) && !stack_full)
                     int_take <= 1'b1;
                  else resume_next <= 1'b1;
               end
            end
            default: state_r <= ST_RUN;
         endcase
         if (subrun_r && high_osc_ready_r) subrun_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Clock sources and ready flags
   // ----------------------------------------
   // Fast oscillator runs unless slow run or a mode that stops the system clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_r <= 1'b0;
         fast_on_r <= 1'b1;
         low_on_r <= 1'b1;
         high_osc_ready_r <= 1'b0;
         low_osc_ready_r <= 1'b0;
      end else begin
         if (enter_lp) begin
            if (lp_sel != PAUSE_FULL) begin
               fast_on_r <= 1'b0;
               high_osc_ready_r <= 1'b0;
            end
            if (lp_sel == DEEP_STOP) begin
               low_on_r <= 1'b0;
               low_osc_ready_r <= 1'b0;
            end
         end else if (wake_any) begin
            // Restart whatever the stopped mode switched off
            fast_on_r <= !slow_r || fast_on_r;
            low_on_r <= 1'b1;
         end else if (state_r == ST_RUN) begin
            if (want_slow && !slow_r && low_osc_ready_r) begin
               slow_r <= 1'b1;
               fast_on_r <= 1'b0;
               high_osc_ready_r <= 1'b0;
            end
            if (!want_slow && slow_r) begin
               fast_on_r <= 1'b1;
               if (high_osc_ready_r) slow_r <= 1'b0;
            end
         end
         if (done_high) high_osc_ready_r <= 1'b1;
         if (done_low) low_osc_ready_r <= 1'b1;
      end
   end

   // Clock enables per mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         system_clock_en <= 1'b0;
         timebase_clock_en <= 1'b0;
         sub_clock_en <= 1'b0;
         wdt_source_en <= 1'b0;
         wdt_hold <= 1'b0;
      end else begin
         system_clock_en <= (state_r == ST_RUN) ||
                            (state_r == ST_LOW_POWER && lp_mode_r == PAUSE_FULL) ||
                            (state_r == ST_WAKE && subrun_r);
         timebase_clock_en <= (state_r != ST_LOW_POWER) ||
                              lp_mode_r == PAUSE_SUB || lp_mode_r == PAUSE_FULL;
         sub_clock_en <= low_on_r && low_osc_ready_r;
         wdt_source_en <= wdt_enable && !(state_r == ST_LOW_POWER && lp_mode_r == DEEP_STOP);
         wdt_hold <= !wdt_enable || (state_r == ST_LOW_POWER && lp_mode_r == DEEP_STOP);
      end
   end

   assign sysclk_slow = slow_r || subrun_r;
   assign periph_clock_slow = sysclk_slow;
   assign run_on_sub = subrun_r;
   assign fast_clock_en = fast_on_r;
   assign low_osc_en = low_on_r;
   assign cpu_halt = (state_r != ST_RUN) && !(state_r == ST_WAKE && subrun_r);
   assign hold_state = state_r == ST_LOW_POWER;

   // ----------------------------------------
   // Watchdog clear and status flags
   // ----------------------------------------
   // clear on entry
   always_ff @(posedge aclk) begin
      if (!aresetn) wdt_clear <= 1'b0;
      else wdt_clear <= enter_lp || clr_wdt;
   end

   // Set wins over clear when both land in one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         powerdown_flag_r <= 1'b0;
         timeout_flag_r <= 1'b0;
      end else begin
         if (clr_wdt) powerdown_flag_r <= 1'b0;
         if (enter_lp) begin
            powerdown_flag_r <= 1'b1;
            timeout_flag_r <= 1'b0;
         end
         if (wdt_overflow) timeout_flag_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   // Address and data are held separately, so they may come in either order
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_lane_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == MODE_OFS || aw_addr_r == CTRL_OFS ||
                            aw_addr_r == WAKE_OFS || aw_addr_r == STATUS_OFS) ?
                           RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writable registers; status is read-only and ignores writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= MODE_RESET;
         ctrl_r <= CTRL_RESET;
         wake_en_r <= PINS'(WAKE_RESET);
      end else if (wr_fire && w_lane_r) begin
         if (aw_addr_r == MODE_OFS) mode_r <= w_data_r;
         if (aw_addr_r == CTRL_OFS) ctrl_r <= w_data_r;
         if (aw_addr_r == WAKE_OFS) wake_en_r <= PINS'(w_data_r);
      end
   end

   always_comb begin
      status_word = '0;
      status_word[PDF_BIT] = powerdown_flag_r;
      status_word[TOF_BIT] = timeout_flag_r;
      status_word[LRDY_BIT] = low_osc_ready_r;
      status_word[HRDY_BIT] = high_osc_ready_r;
      status_word[SLOW_BIT] = slow_r;
      status_word[SUBRUN_BIT] = subrun_r;
      status_word[LP_BIT] = state_r == ST_LOW_POWER;
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            MODE_OFS: s_axi_rdata <= {24'h000000, mode_r};
            CTRL_OFS: s_axi_rdata <= {24'h000000, ctrl_r};
            WAKE_OFS: s_axi_rdata <= 32'(wake_en_r);
            STATUS_OFS: s_axi_rdata <= status_word;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // power_mode_controller

//--- logic/power_mode_pkg.sv
/*
 Constants, field layouts and state types shared by the power mode
 controller and its helpers. Assumes a single always-running control
 clock of 50 MHz and a 32-bit AXI4-Lite register bus.
*/
// What this block does
// - Clear high select, divider 000/001: slow run
// - Slow switch completes only once low oscillator ready
// - High select set or divider 010-111: fast run
// - High oscillator ready flag readable by software
// - Stop, watchdog and detector off: deep stop
// - Stop, watchdog or detector on: sub clock stop
// - Watchdog cleared on entry, keeps counting if enabled
// - Idle, no system clock: timebase and sub run
// - Idle with system clock: all clocks keep running
// - Memory, registers, ports held during low power
// - Entry sets powerdown flag, clears timeout flag
// - Wake on port fall, interrupt or watchdog overflow
// - Powerdown cleared by reset or clear watchdog
// - Watchdog wake sets timeout, resets PC and SP
// - Per pin wake enable; resume after stop
// - Disabled interrupt or full stack: resume, keep pending
// - Interrupt pending before entry cannot wake
// - One startup timer, high oscillator goes first
// - After deep stop from fast run, execute once high ready; from slow run, once low ready
// - Sub clock stop, crystal, fast wake: run slow
// - Peripheral clock follows system clock source
// - Watchdog source clock follows watchdog enable
// - High ready after 128 crystal or 16 RC cycles
// - Fast wake runs on sub clock until 128 cycles
// - Switching to slow clock turns fast clock off
package power_mode_pkg;
   // Register byte offsets
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] WAKE_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   // Mode register fields
   localparam int HCS_BIT = 0;
   localparam int IDLE_BIT = 1;
   localparam int FAST_WAKE_BIT = 2;
   localparam int CDS_LSB = 5;
   localparam logic [7:0] MODE_RESET = 8'h01;
   localparam logic [2:0] CDS_SLOW_MAX = 3'h1;
   // Control register fields
   localparam int SYSIDLE_BIT = 0;
   localparam int WDT_EN_BIT = 1;
   localparam int LVD_EN_BIT = 2;
   localparam int XTAL_BIT = 3;
   localparam logic [7:0] CTRL_RESET = 8'h02;
   localparam logic [7:0] WAKE_RESET = 8'h00;
   // Status register fields
   localparam int PDF_BIT = 0;
   localparam int TOF_BIT = 1;
   localparam int LRDY_BIT = 2;
   localparam int HRDY_BIT = 3;
   localparam int SLOW_BIT = 4;
   localparam int SUBRUN_BIT = 5;
   localparam int LP_BIT = 6;
   // Startup lengths in oscillator cycles
   localparam int HIGH_XTAL_CYCLES = 128;
   localparam int HIGH_RC_CYCLES = 16;
   localparam int LOW_XTAL_CYCLES = 1024;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {DEEP_STOP, STOP_SUB, PAUSE_SUB, PAUSE_FULL} lp_mode_type;
   typedef enum logic [1:0] {ST_RUN, ST_LOW_POWER, ST_WAKE} state_type;
   typedef enum logic [1:0] {CAUSE_PORT, CAUSE_INT, CAUSE_WDT} cause_type;
endpackage

//--- logic/startup_timer.sv
/*
 Shared oscillator startup counter. Assumes oscillator ticks arrive as
 one-cycle pulses synchronous to the control clock.
*/
`timescale 1ns/1ps
module startup_timer
   import power_mode_pkg::*;
#(
   parameter int LOW_CYCLES = LOW_XTAL_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic high_is_xtal,
   input wire logic req_high,
   input wire logic req_low,
   input wire logic tick_high,
   input wire logic tick_low,
   output logic done_high,
   output logic done_low
);
   logic busy_r;
   logic owner_low_r;
   logic [15:0] count_r;
   logic [15:0] len;
   logic tick;
   // Length depends on which oscillator owns the counter
   assign len = owner_low_r ? 16'(LOW_CYCLES) :
                (high_is_xtal ? 16'(HIGH_XTAL_CYCLES) : 16'(HIGH_RC_CYCLES));
   assign tick = owner_low_r ? tick_low : tick_high;
   // high first
   // The high request always wins the idle counter, so the low crystal waits
   always_ff @(posedge aclk) begin
      done_high <= 1'b0;
      done_low <= 1'b0;
      if (!aresetn) begin
         busy_r <= 1'b0;
         owner_low_r <= 1'b0;
         count_r <= '0;
      end else if (!busy_r) begin
         count_r <= '0;
         if (req_high || req_low) begin
            busy_r <= 1'b1;
            owner_low_r <= !req_high;
         end
      end else if (owner_low_r ? !req_low : !req_high) begin
         busy_r <= 1'b0; // Oscillator switched off again: abort
      end else if (tick) begin
         count_r <= count_r + 16'h0001;
         // Reaching or passing the length ends the count, so a length change mid-count cannot wrap
         if (count_r + 16'h0001 >= len) begin
            busy_r <= 1'b0;
            done_high <= !owner_low_r;
            done_low <= owner_low_r;
         end
      end
   end
endmodule // startup_timer

//--- logic/wake_detect.sv
/*
 Port falling-edge and new-interrupt wake detection. Assumes port and
 interrupt levels are synchronous to the always-running control clock.
*/
`timescale 1ns/1ps
module wake_detect #(
   parameter int PINS = 8,
   parameter int INTS = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic armed,
   input wire logic [PINS-1:0] port_a,
   input wire logic [PINS-1:0] port_wake_enable,
   input wire logic [INTS-1:0] int_req,
   output logic port_wake,
   output logic [INTS-1:0] int_new
);
   logic armed_d_r;
   logic [PINS-1:0] port_prev_r;
   logic [PINS-1:0] fall;
   logic [INTS-1:0] int_old_r;
   // own clock
   // Runs on the control clock, which is never gated, not the system clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_d_r <= 1'b0;
         int_old_r <= '0;
      end else begin
         armed_d_r <= armed;
         if (armed && !armed_d_r) int_old_r <= int_req;
      end
   end
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      always_ff @(posedge aclk) begin
         if (!aresetn) port_prev_r[i] <= 1'b1;
         else port_prev_r[i] <= port_a[i];
      end
      assign fall[i] = port_prev_r[i] && !port_a[i] && port_wake_enable[i];
   end
   assign port_wake = armed && armed_d_r && |fall;
   assign int_new = (armed && armed_d_r) ? (int_req & ~int_old_r) : '0;
endmodule // wake_detect

//--- bench/power_mode_monitor.sv
/*
 Checker for the power mode controller top ports.
 Assumes one always-running clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module power_mode_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stop_exec,
   input wire logic clr_wdt,
   input wire logic cpu_halt,
   input wire logic hold_state,
   input wire logic resume_next,
   input wire logic int_take,
   input wire logic pc_sp_reset,
   input wire logic wdt_clear,
   input wire logic system_clock_en,
   input wire logic timebase_clock_en,
   input wire logic sub_clock_en,
   input wire logic fast_clock_en,
   input wire logic sysclk_slow,
   input wire logic periph_clock_slow,
   input wire logic run_on_sub
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // Stop entry, wake-up and clock switching
   // ----------------------------------------
   sequence s_stop;
      stop_exec && !cpu_halt;
   endsequence
   sequence s_settled;
      s_stop ##2 1'b1;
   endsequence
   a_stop_holds: assert property (s_stop |=> hold_state && wdt_clear)
      else $error("stop not frozen");
   a_clr_wdt: assert property (clr_wdt |=> wdt_clear)
      else $error("watchdog clear missing");
   a_lp_halt: assert property (hold_state |-> cpu_halt)
      else $error("cpu runs in low power");
   a_deep_clocks: assert property (s_settled ##0 !sub_clock_en |-> !system_clock_en && !timebase_clock_en)
      else $error("clock running in deep stop");
   a_idle_clocks: assert property (s_settled ##0 system_clock_en |-> timebase_clock_en && sub_clock_en)
      else $error("full idle clocks missing");
   a_wake_once: assert property ($onehot0({resume_next, int_take, pc_sp_reset}))
      else $error("two wake actions");
   // A fast wake lets the core run on the sub clock before the answer
   a_wake_halted: assert property (resume_next || int_take || pc_sp_reset |-> $past(cpu_halt || run_on_sub))
      else $error("wake action while running");
   // Fast clock off soon after moving to slow clock
   a_slow_fast_off: assert property ($rose(sysclk_slow) && !run_on_sub |-> ##[0:2] !fast_clock_en)
      else $error("fast clock left on");
   a_periph_follow: assert property (periph_clock_slow == sysclk_slow)
      else $error("peripheral clock differs");
endmodule // power_mode_monitor

bind power_mode_controller power_mode_monitor mon (.*);

//--- bench/power_mode_controller_tb.sv
/*
 Self-checking bench for the power mode controller.
 Assumes oscillator ticks every cycle; the bench plays CPU and bus master.
*/
`timescale 1ns/1ps
module power_mode_controller_tb;
   import power_mode_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, port_a, int_req, int_enable;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic stop_exec, clr_wdt, wdt_overflow, stack_full, high_osc_tick, low_osc_tick;
   logic cpu_halt, hold_state, resume_next, int_take, pc_sp_reset, wdt_clear, wdt_hold;
   logic system_clock_en, timebase_clock_en, sub_clock_en, wdt_source_en, fast_clock_en;
   logic low_osc_en, sysclk_slow, periph_clock_slow, run_on_sub;
   logic [7:0] mtab [5] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h05};
   logic [7:0] ctab [5] = '{8'h00, 8'h02, 8'h00, 8'h01, 8'h0A};
   logic [5:0] etab [5] = '{6'h02, 6'h0D, 6'h1B, 6'h3B, 6'h0D};
   int fail_count, comparisons;

   power_mode_controller #(.LOW_CYCLES(8)) dut (.*);

   // Free-running bus clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string t);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t %s seen %0h want %0h", $time, t, s, e);
      end
   endtask

   // Bounded waits all end here when they run out
   task automatic guard(input int k);
      if (k >= 200) begin
         fail_count++;
         $display("BAD %0t wait ran out", $time);
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
      logic ap = 1'b1, wp = 1'b1;
      int k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Address and data may be taken at different edges
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awready === 1'b1) ap = 1'b0;
         if (s_axi_wready === 1'b1) wp = 1'b0;
         s_axi_awvalid <= ap;
         s_axi_wvalid <= wp;
      end while ((ap || wp) && k < 200);
      do begin
         @(posedge aclk);
         k++;
      end while (s_axi_bvalid !== 1'b1 && k < 200);
      s_axi_bready <= 1'b0;
      guard(k);
      chk(s_axi_bresp, e, "bresp");
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                     input logic [1:0] r);
      int k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
      end while (s_axi_arready !== 1'b1 && k < 200);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         k++;
      end while (s_axi_rvalid !== 1'b1 && k < 200);
      s_axi_rready <= 1'b0;
      guard(k);
      chk(s_axi_rdata & {24'h0, m}, {24'h0, e}, "rdata");
      chk(s_axi_rresp, r, "rresp");
   endtask

   // w selects stop, clear watchdog or watchdog overflow
   task automatic pulse(input int w);
      {stop_exec, clr_wdt, wdt_overflow} <= 3'h4 >> w;
      @(posedge aclk);
      {stop_exec, clr_wdt, wdt_overflow} <= 3'h0;
   endtask

   task automatic wake_wait(input logic [2:0] e);
      int k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (!(resume_next | int_take | pc_sp_reset) && k < 200);
      guard(k);
      chk({pc_sp_reset, int_take, resume_next}, e, "wake");
   endtask

   task automatic until_lvl(ref logic s, input logic v);
      int k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (s !== v && k < 200);
      guard(k);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, int_req, int_enable} = '0;
      {stop_exec, clr_wdt, wdt_overflow, stack_full} = 4'h0;
      {high_osc_tick, low_osc_tick} = 2'h3;
      s_axi_wstrb = 4'hF;
      port_a = 8'hFF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      wake_wait(3'h1);
      rd(STATUS_OFS, 8'h08, 8'h08, RESP_OKAY);
      rd(MODE_OFS, 8'hFF, MODE_RESET, RESP_OKAY);
      rd(CTRL_OFS, 8'hFF, CTRL_RESET, RESP_OKAY);
      rd(WAKE_OFS, 8'hFF, WAKE_RESET, RESP_OKAY);
      rd(8'h10, 8'hFF, 8'h00, RESP_SLVERR);
      $display("reset test done");
      wr(MODE_OFS, 8'h20, RESP_OKAY);
      until_lvl(sysclk_slow, 1'b1);
      rd(STATUS_OFS, 8'h14, 8'h14, RESP_OKAY);
      chk(fast_clock_en, 1'b0, "fast off");
      // divider 010 returns to fast run
      wr(MODE_OFS, 8'h40, RESP_OKAY);
      until_lvl(sysclk_slow, 1'b0);
      rd(STATUS_OFS, 8'h18, 8'h08, RESP_OKAY);
      $display("switch test done");
      wr(WAKE_OFS, 8'h01, RESP_OKAY);
      // every low power mode, then fast wake
      // The wait lets a restarting low oscillator settle before the clocks are checked
      for (int i = 0; i < 5; i++) begin
         wr(MODE_OFS, mtab[i], RESP_OKAY);
         wr(CTRL_OFS, ctab[i], RESP_OKAY);
         pulse(0);
         repeat (12) @(posedge aclk);
         chk({system_clock_en, timebase_clock_en, sub_clock_en, wdt_source_en, wdt_hold,
              low_osc_en}, etab[i], "clk");
         chk(hold_state & cpu_halt, 1'b1, "hold");
         rd(STATUS_OFS, 8'h03, 8'h01, RESP_OKAY);
         port_a <= 8'hFE;
         wake_wait(3'h1);
         chk(run_on_sub, i == 4, "subrun");
         port_a <= 8'hFF;
      end
      until_lvl(run_on_sub, 1'b0);
      $display("mode test done");
      wr(CTRL_OFS, 8'h02, RESP_OKAY);
      pulse(0);
      repeat (3) @(posedge aclk);
      pulse(2);
      wake_wait(3'h4);
      rd(STATUS_OFS, 8'h03, 8'h03, RESP_OKAY);
      pulse(1);
      rd(STATUS_OFS, 8'h01, 8'h00, RESP_OKAY);
      $display("watchdog test done");
      wr(CTRL_OFS, 8'h00, RESP_OKAY);
      int_req <= 8'h01;
      int_enable <= 8'h0C;
      for (int j = 0; j < 3; j++) begin
         stack_full <= (j == 2);
         pulse(0);
         repeat (20) @(posedge aclk);
         chk(cpu_halt, 1'b1, "pending");
         int_req <= (8'h04 << j) - 8'h01;
         wake_wait((j == 1) ? 3'h2 : 3'h1);
      end
      $display("interrupt test done");
      close_out();
   end
endmodule // power_mode_controller_tb
